// File: icyc_divider.sv
// instruction cycle divider: one-clock tick every DIV system clocks
// assumes a free running sys_clk_i and synchronous active low reset
`timescale 1ns/10ps
`include "rar_cfg.svh"

module icyc_divider #(
  parameter int unsigned DIV = `RAR_ICYC_CLKS
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // instruction cycle enable
  output logic      tick_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          tick_ff;
  logic          nxt_tick;

  // wrap counter, tick on the last count
  always_comb begin
    nxt_tick = (cnt_ff == CW'(DIV - 1));
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + CW'(1);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule : icyc_divider

// File: rar_cfg.svh
// constants for the return and rotate execution block
// assumes inclusion by bare name from the design modules
`ifndef RAR_CFG_SVH
`define RAR_CFG_SVH

// data path widths
`define RAR_DATA_W      8
`define RAR_FADDR_W     7
`define RAR_PC_W        15
// bit positions inside a data byte
`define RAR_MSB_POS     7
// instruction cycles per instruction
`define RAR_RET_CYCLES  2
`define RAR_ROT_CYCLES  1
// default system clocks per instruction cycle
`define RAR_ICYC_CLKS   4

`endif

// File: rar_pkg.sv
// types shared by the return and rotate execution block
// assumes nothing beyond a SystemVerilog compiler
package rar_pkg;

  // operation offered by instruction decode
  typedef enum logic [1:0] {
    OP_NONE,
    OP_RETURN_WITH_LITERAL,
    OP_RETURN,
    OP_ROTATE_LEFT_CARRY
  } op_t;

  // execution sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_RET_WAIT
  } state_t;

endpackage : rar_pkg

// File: return_and_rotate_exec.sv
// execution of return-with-literal, return and rotate-left-through-carry
// assumes decode holds issue_i/op_i stable until a tick with busy_o low,
// and that file read data and carry are valid while the op is offered
`timescale 1ns/10ps
`include "rar_cfg.svh"

module return_and_rotate_exec #(
  parameter int unsigned ICYC_CLKS = `RAR_ICYC_CLKS,
  parameter int unsigned DW        = `RAR_DATA_W,
  parameter int unsigned AW        = `RAR_FADDR_W,
  parameter int unsigned PW        = `RAR_PC_W
) (
  // clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            rst_n_i,
  // instruction decode
  input  wire logic            issue_i,
  input  wire rar_pkg::op_t    op_i,
  input  wire logic [DW-1:0]   literal_i,
  input  wire logic [AW-1:0]   f_addr_i,
  input  wire logic            dest_i,
  // operand sources
  input  wire logic [DW-1:0]   f_rdata_i,
  input  wire logic            carry_i,
  input  wire logic [PW-1:0]   stack_top_entry_i,
  // working register write
  output logic                 w_we_o,
  output logic [DW-1:0]        w_data_o,
  // file register write
  output logic                 f_we_o,
  output logic [AW-1:0]        f_addr_o,
  output logic [DW-1:0]        f_data_o,
  // program counter and stack
  output logic                 pc_load_o,
  output logic [PW-1:0]        pc_o,
  output logic                 pop_o,
  // carry flag write
  output logic                 carry_we_o,
  output logic                 carry_o,
  // sequencing
  output logic                 busy_o,
  output logic                 done_o
);

  logic            tick;
  logic            take;
  logic [DW:0]     rot;
  rar_pkg::state_t state_ff;
  rar_pkg::state_t nxt_state;
  logic            w_we_ff,  nxt_w_we;
  logic [DW-1:0]   w_dat_ff, nxt_w_dat;
  logic            f_we_ff,  nxt_f_we;
  logic [AW-1:0]   f_adr_ff, nxt_f_adr;
  logic [DW-1:0]   f_dat_ff, nxt_f_dat;
  logic            pc_ld_ff, nxt_pc_ld;
  logic [PW-1:0]   pc_ff,    nxt_pc;
  logic            pop_ff,   nxt_pop;
  logic            c_we_ff,  nxt_c_we;
  logic            c_ff,     nxt_c;
  logic            busy_ff,  nxt_busy;
  logic            done_ff,  nxt_done;

  // {carry out, result}: old msb leaves, old carry enters bit 0
  function automatic logic [DW:0] rotl_carry(input logic [DW-1:0] d, input logic cin);
    rotl_carry = {d, cin};
  endfunction : rotl_carry

  // instruction cycle enable
  icyc_divider #(
    .DIV    (ICYC_CLKS)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );

  // an op is taken only on a tick while idle
  assign take = tick && issue_i && (state_ff == rar_pkg::ST_IDLE);
  assign rot  = rotl_carry(f_rdata_i, carry_i);

  // sequencer and result strobes; strobes last one clock
  always_comb begin
    nxt_state = state_ff;
    nxt_w_we  = 1'b0;
    nxt_w_dat = w_dat_ff;
    nxt_f_we  = 1'b0;
    nxt_f_adr = f_adr_ff;
    nxt_f_dat = f_dat_ff;
    nxt_pc_ld = 1'b0;
    nxt_pc    = pc_ff;
    nxt_pop   = 1'b0;
    nxt_c_we  = 1'b0; // flags untouched unless rotating
    nxt_c     = c_ff;
    nxt_busy  = busy_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      rar_pkg::ST_IDLE: begin
        if (take) begin
          case (op_i)
            rar_pkg::OP_RETURN_WITH_LITERAL: begin
              nxt_w_we  = 1'b1;
              nxt_w_dat = literal_i;
              nxt_pc_ld = 1'b1;
              nxt_pc    = stack_top_entry_i;
              nxt_pop   = 1'b1;
              nxt_busy  = 1'b1; // second cycle refills the fetch
              nxt_state = rar_pkg::ST_RET_WAIT;
            end
            rar_pkg::OP_RETURN: begin
              nxt_pc_ld = 1'b1;
              nxt_pc    = stack_top_entry_i;
              nxt_pop   = 1'b1;
              nxt_busy  = 1'b1;
              nxt_state = rar_pkg::ST_RET_WAIT;
            end
            rar_pkg::OP_ROTATE_LEFT_CARRY: begin
              nxt_c_we = 1'b1;
              nxt_c    = rot[DW];
              if (dest_i) begin
                nxt_f_we  = 1'b1;
                nxt_f_adr = f_addr_i;
                nxt_f_dat = rot[DW-1:0];
              end else begin
                nxt_w_we  = 1'b1;
                nxt_w_dat = rot[DW-1:0];
              end
              nxt_done = 1'b1; // single instruction cycle
            end
            default: begin
              nxt_done = 1'b0;
            end
          endcase
        end
      end
      rar_pkg::ST_RET_WAIT: begin
        // second instruction cycle ends on the next tick
        if (tick) begin
          nxt_busy  = 1'b0;
          nxt_done  = 1'b1;
          nxt_state = rar_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = rar_pkg::ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= rar_pkg::ST_IDLE;
      w_we_ff  <= 1'b0;
      w_dat_ff <= '0;
      f_we_ff  <= 1'b0;
      f_adr_ff <= '0;
      f_dat_ff <= '0;
      pc_ld_ff <= 1'b0;
      pc_ff    <= '0;
      pop_ff   <= 1'b0;
      c_we_ff  <= 1'b0;
      c_ff     <= 1'b0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      w_we_ff  <= nxt_w_we;
      w_dat_ff <= nxt_w_dat;
      f_we_ff  <= nxt_f_we;
      f_adr_ff <= nxt_f_adr;
      f_dat_ff <= nxt_f_dat;
      pc_ld_ff <= nxt_pc_ld;
      pc_ff    <= nxt_pc;
      pop_ff   <= nxt_pop;
      c_we_ff  <= nxt_c_we;
      c_ff     <= nxt_c;
      busy_ff  <= nxt_busy;
      done_ff  <= nxt_done;
    end
  end

  // outputs straight from flops
  assign w_we_o     = w_we_ff;
  assign w_data_o   = w_dat_ff;
  assign f_we_o     = f_we_ff;
  assign f_addr_o   = f_adr_ff;
  assign f_data_o   = f_dat_ff;
  assign pc_load_o  = pc_ld_ff;
  assign pc_o       = pc_ff;
  assign pop_o      = pop_ff;
  assign carry_we_o = c_we_ff;
  assign carry_o    = c_ff;
  assign busy_o     = busy_ff;
  assign done_o     = done_ff;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // done of a return lands one clock after the tick that closes its second cycle
  localparam int RET_LAT = ICYC_CLKS + 1;

  sequence ret_start_s;
    take && (op_i == rar_pkg::OP_RETURN || op_i == rar_pkg::OP_RETURN_WITH_LITERAL);
  endsequence
  sequence rot_start_s;
    take && op_i == rar_pkg::OP_ROTATE_LEFT_CARRY;
  endsequence

  lit_to_w_a: assert property (
    take && op_i == rar_pkg::OP_RETURN_WITH_LITERAL |=>
      w_we_o && w_data_o == $past(literal_i) && !carry_we_o)
    else $error("literal not placed in working register");
  pc_from_stack_a: assert property (
    ret_start_s |=> pc_load_o && pop_o && pc_o == $past(stack_top_entry_i))
    else $error("pc not loaded from stack top entry");
  ret_two_cycles_a: assert property (
    ret_start_s |-> ##[RET_LAT:RET_LAT] (done_o && !busy_o))
    else $error("return did not span two instruction cycles");
  ret_busy_hold_a: assert property (
    state_ff == rar_pkg::ST_RET_WAIT |-> busy_o && !done_o && !carry_we_o)
    else $error("return second cycle not held busy");
  ret_wait_end_a: assert property (
    state_ff == rar_pkg::ST_RET_WAIT && tick |=> done_o && !busy_o && !pc_load_o)
    else $error("return second cycle did not end on tick");
  rot_carry_a: assert property (
    rot_start_s |=> carry_we_o && carry_o == $past(f_rdata_i[`RAR_MSB_POS]))
    else $error("rotate carry out wrong");
  rot_to_w_a: assert property (
    rot_start_s and !dest_i |=> w_we_o && !f_we_o
      && w_data_o == {$past(f_rdata_i[DW-2:0]), $past(carry_i)})
    else $error("rotate to working register wrong");
  rot_to_f_a: assert property (
    rot_start_s and dest_i |=> f_we_o && !w_we_o && f_addr_o == $past(f_addr_i)
      && f_data_o == {$past(f_rdata_i[DW-2:0]), $past(carry_i)})
    else $error("rotate write back wrong");
  rot_single_a: assert property (
    rot_start_s |=> done_o && !busy_o && !pop_o && !pc_load_o)
    else $error("rotate not single cycle");

endmodule : return_and_rotate_exec

// File: tb_top.sv
// self-checking bench for the return and rotate execution block
// assumes the design files and rar_pkg are compiled first; bench drives all ports
`timescale 1ns/10ps

module tb_top;
  localparam int unsigned ICYC = 4;
  // design inputs, all defined at time zero
  logic               sys_clk_i         = 1'b0;
  logic               rst_n_i           = 1'b0;
  logic               issue_i           = 1'b0;
  rar_pkg::op_t       op_i              = rar_pkg::OP_NONE;
  logic [7:0]         literal_i         = 8'h00;
  logic [6:0]         f_addr_i          = 7'h00;
  logic               dest_i            = 1'b0;
  logic [7:0]         f_rdata_i         = 8'h00;
  logic               carry_i           = 1'b0;
  logic [14:0]        stack_top_entry_i = 15'h0000;
  // design outputs
  logic               w_we_o, f_we_o, pc_load_o, pop_o, carry_we_o, carry_o, busy_o, done_o;
  logic [7:0]         w_data_o, f_data_o;
  logic [6:0]         f_addr_o;
  logic [14:0]        pc_o;
  int                 bad_count = 0;
  int                 n_checks  = 0;
  int                 cyc       = 0;
  logic [7:0]         w_last    = 8'h00;

  return_and_rotate_exec #(.ICYC_CLKS(ICYC)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .op_i(op_i),
    .literal_i(literal_i), .f_addr_i(f_addr_i), .dest_i(dest_i), .f_rdata_i(f_rdata_i),
    .carry_i(carry_i), .stack_top_entry_i(stack_top_entry_i), .w_we_o(w_we_o),
    .w_data_o(w_data_o), .f_we_o(f_we_o), .f_addr_o(f_addr_o), .f_data_o(f_data_o),
    .pc_load_o(pc_load_o), .pc_o(pc_o), .pop_o(pop_o), .carry_we_o(carry_we_o),
    .carry_o(carry_o), .busy_o(busy_o), .done_o(done_o));

  // 200 MHz clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // hang guard: the whole sequence needs well under a thousand clocks
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      bad_count++;
    end
  endtask : check

  // offer one op and hold it until the answer cycle, which is where we return
  task automatic offer(input rar_pkg::op_t op, input logic [7:0] lit, input logic d,
                       input logic [7:0] fd, input logic c, input logic [14:0] top);
    int n;
    @(posedge sys_clk_i);
    issue_i           <= 1'b1;
    op_i              <= op;
    literal_i         <= lit;
    f_addr_i          <= {lit[2:0], fd[3:0]};
    dest_i            <= d;
    f_rdata_i         <= fd;
    carry_i           <= c;
    stack_top_entry_i <= top;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (w_we_o !== 1'b1 && f_we_o !== 1'b1 && pc_load_o !== 1'b1 && n < 4 * ICYC);
    check(16'(n < 4 * ICYC), 16'h0001, "no answer");
  endtask : offer

  // drop the request well before the next tick, then strobes must be gone
  task automatic release_op();
    @(posedge sys_clk_i);
    issue_i <= 1'b0;
    #1;
    check({w_we_o, f_we_o, pc_load_o, pop_o, carry_we_o}, 16'h0000, "pulse too long");
  endtask : release_op

  // rotate through carry, both destinations and both carry values
  task automatic rotate_cases();
    logic [7:0] fv [4] = '{8'hE6, 8'h81, 8'h00, 8'hFF};
    logic [3:0] cv = 4'b0110;
    logic [3:0] dv = 4'b1100;
    for (int i = 0; i < 4; i++) begin
      offer(rar_pkg::OP_ROTATE_LEFT_CARRY, 8'(i), dv[i], fv[i], cv[i], 15'h7FFF);
      if (!dv[i]) w_last = {fv[i][6:0], cv[i]};
      check(w_data_o, w_last, "rotate w");
      check({w_we_o, f_we_o}, {~dv[i], dv[i]}, "rotate dest");
      if (dv[i]) begin
        check(f_data_o, {fv[i][6:0], cv[i]}, "rotate f");
        check(f_addr_o, {3'(i), fv[i][3:0]}, "rotate addr");
      end
      check({carry_we_o, carry_o}, {1'b1, fv[i][7]}, "carry out");
      check({done_o, busy_o, pc_load_o, pop_o}, 16'h0008, "one cycle");
      release_op();
    end
  endtask : rotate_cases

  // both returns: effects in cycle one, done after the second cycle
  task automatic return_case(input logic lit_en, input logic [7:0] lit, input logic [14:0] top);
    int n;
    offer(lit_en ? rar_pkg::OP_RETURN_WITH_LITERAL : rar_pkg::OP_RETURN,
          lit, 1'b1, 8'hFF, 1'b1, top);
    if (lit_en) w_last = lit;
    check(w_we_o, lit_en, "literal write");
    check(w_data_o, w_last, "literal value");
    check({pc_load_o, pop_o, pc_o}, {2'b11, top}, "pc from stack");
    check({carry_we_o, f_we_o, busy_o, done_o}, 16'h0002, "return flags");
    release_op();
    n = 1;
    while (done_o !== 1'b1 && n < 4 * ICYC) begin
      check(busy_o, 1'b1, "busy in second cycle");
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check(16'(n), 16'(ICYC), "two instruction cycles");
    check({busy_o, carry_we_o}, 16'h0000, "return end");
  endtask : return_case

  // op none is taken on ticks and must leave every strobe low
  task automatic none_case();
    @(posedge sys_clk_i);
    issue_i <= 1'b1;
    op_i    <= rar_pkg::OP_NONE;
    repeat (2 * ICYC) begin
      @(posedge sys_clk_i);
      #1;
      check({w_we_o, f_we_o, pc_load_o, pop_o, carry_we_o, done_o}, 32'h0, "idle op");
    end
    @(posedge sys_clk_i);
    issue_i <= 1'b0;
  endtask : none_case

  // reset in the second cycle of a return must clear the sequencer and outputs
  task automatic reset_case();
    offer(rar_pkg::OP_RETURN, 8'h00, 1'b0, 8'h00, 1'b0, 15'h0456);
    @(posedge sys_clk_i);
    issue_i <= 1'b0;
    rst_n_i <= 1'b0;
    repeat (ICYC) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    w_last = 8'h00;
    check({busy_o, done_o, pc_load_o, pop_o, pc_o, w_data_o}, 32'h0, "reset");
  endtask : reset_case

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rotate_cases();
    return_case(1'b1, 8'hFF, 15'h0123);
    return_case(1'b0, 8'h00, 15'h7FFF);
    return_case(1'b1, 8'h00, 15'h0000);
    none_case();
    reset_case();
    rotate_cases();
    finish_test();
  end
endmodule : tb_top
